// *** design/uart_page_regs.svh ***
// register indices, codes and reset values of the paged uart register file
`ifndef UART_PAGE_REGS_SVH
`define UART_PAGE_REGS_SVH

// ============================================================
// bus address layout
`define REG_IDX_LSB 2
`define REG_IDX_MSB 4
`define REG_SPAN_MSB 5

// ============================================================
// register indices, base page
`define IDX_DATA 3'h0
`define IDX_INT_EN 3'h1
`define IDX_INT_SRC 3'h2
`define IDX_LINE_CTRL 3'h3
`define IDX_MODEM_CTRL 3'h4
`define IDX_LINE_STAT 3'h5
`define IDX_MODEM_STAT 3'h6
`define IDX_SCRATCH 3'h7
// divisor page
`define IDX_DIV_LOW 3'h0
`define IDX_DIV_HIGH 3'h1
// count page
`define IDX_TX_COUNT 3'h0
`define IDX_RX_COUNT 3'h1
`define IDX_FLOW_STAT 3'h2
// feature page
`define IDX_PAGE_KEY 3'h0
`define IDX_AUTO_TOG 3'h1
`define IDX_ENH_FEAT 3'h2
`define IDX_RESUME_A 3'h4
`define IDX_RESUME_B 3'h5
`define IDX_PAUSE_A 3'h6
`define IDX_PAUSE_B 3'h7
// extended page
`define IDX_REPEAT 3'h1
`define IDX_EXTRA_FEAT 3'h2
`define IDX_TX_TRIG 3'h4
`define IDX_RX_TRIG 3'h5
`define IDX_FLOW_UP 3'h6
`define IDX_FLOW_LO 3'h7

// ============================================================
// page selection codes and bit positions
`define LINE_DIV_BIT 7
`define LINE_FEAT_CODE 8'hBF
`define KEY_OPEN 8'hA5
`define KEY_CLOSE 8'hA4
`define MODEM_PAGE_BIT 6
`define ENH_WE_BIT 4
`define FIFO_EN_BIT 0
`define MODE256_BIT 0
`define AUTO_TOG_ON 2'h3

// ============================================================
// reset values
`define RST_ZERO 8'h00
`define RST_INT_SRC 8'h01
`define RST_LINE_STAT 8'h60
`define RST_AUTO_TOG 8'hA0
`define RST_TRIG 8'h80
`define RST_DIV 8'hFF

// ============================================================
// 64-byte mode levels, indexed by a two-bit control field
`define LVL_0 8'h00
`define LVL_8 8'h08
`define LVL_16 8'h10
`define LVL_32 8'h20
`define LVL_56 8'h38
`define LVL_60 8'h3C

`endif

// *** design/uart_page_pkg.sv ***
// types shared by the paged uart register file
package uart_page_pkg;

	typedef enum logic [2:0] {
		PAGE_BASE = 3'h0,
		PAGE_DIV = 3'h1,
		PAGE_CNT = 3'h2,
		PAGE_FEAT = 3'h3,
		PAGE_EXT = 3'h4
	} page_t;

endpackage : uart_page_pkg

// *** design/fifo_level_lookup.sv ***
// 64-byte mode thresholds and trigger levels from the fifo control bits
`include "uart_page_regs.svh"

module fifo_level_lookup (
	input wire logic [3:0] ctrlHigh,
	output logic [7:0] flowUpper,
	output logic [7:0] flowLower,
	output logic [7:0] rxTrig,
	output logic [7:0] txTrig
);

	// ============================================================
	// bits 1:0 are control bits 5:4, bits 3:2 are control bits 7:6
	always_comb begin
		unique case (ctrlHigh[1:0])
			2'h0: begin
				flowUpper = `LVL_8;
				txTrig = `LVL_8;
			end
			2'h1: begin
				flowUpper = `LVL_16;
				txTrig = `LVL_16;
			end
			2'h2: begin
				flowUpper = `LVL_56;
				txTrig = `LVL_32;
			end
			2'h3: begin
				flowUpper = `LVL_60;
				txTrig = `LVL_56;
			end
		endcase
		unique case (ctrlHigh[3:2])
			2'h0: begin
				flowLower = `LVL_0;
				rxTrig = `LVL_8;
			end
			2'h1: begin
				flowLower = `LVL_8;
				rxTrig = `LVL_16;
			end
			2'h2: begin
				flowLower = `LVL_16;
				rxTrig = `LVL_56;
			end
			2'h3: begin
				flowLower = `LVL_56;
				rxTrig = `LVL_60;
			end
		endcase
	end

endmodule : fifo_level_lookup

// *** design/uart_page_regfile.sv ***
// paged register file and reset behaviour of one uart channel, apb slave
//
// Contract
// RQ1: extended registers need page state plus address
// RQ2: line control bit 7 maps divisor latches
// RQ3: line control BFh exposes flow characters
// RQ4: line control BFh exposes enhanced feature register
// RQ5: key A5h opens extended page, A4h closes
// RQ6: software sets fifo enable before 256 mode
// RQ7: 256 mode accepts written flow thresholds
// RQ8: 64 mode thresholds follow fifo control bits
// RQ9: 64 mode trigger levels follow fifo control
// RQ10: 256 mode accepts written trigger levels
// RQ11: modem control bit 6 exposes flow status
// RQ12: same page returns tx, rx fill counts
// RQ13: reset sets source, status, toggle, triggers, divisor
// RQ14: reset clears counts, controls, characters, thresholds
// RQ15: modem status resets upper zero, lower inverted inputs
// RQ16: in reset irq floats when select low
// RQ17: in reset irq drives 0 when select high
// RQ18: driver enable and receiver enable low after reset
// RQ19: extra feature bit 0 selects 256 mode
// RQ20: 64 mode thresholds read-only, follow control
`include "uart_page_regs.svh"

module uart_page_regfile #(
	parameter int ADDR_W = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] rxData,
	input wire logic [7:0] intSourceIn,
	input wire logic [7:0] lineStatusIn,
	input wire logic [3:0] modemDeltaIn,
	input wire logic [7:0] txCountIn,
	input wire logic [7:0] rxCountIn,
	input wire logic [7:0] flowStatusIn,
	input wire logic txEmpty256,
	input wire logic rxFull256,
	input wire logic txBusy,
	input wire logic [3:0] modemPins,
	input wire logic irqDriveSelect,
	output logic irqOut,
	output logic irqOe,
	output logic txDriverEnable,
	output logic rxReceiverEnableN,
	output logic [15:0] divisor,
	output logic [7:0] lineControl,
	output logic [7:0] modemControl,
	output logic [7:0] fifoControl,
	output logic [7:0] interruptEnable,
	output logic [7:0] enhancedFeature,
	output logic [7:0] resumeCharA,
	output logic [7:0] resumeCharB,
	output logic [7:0] pauseCharA,
	output logic [7:0] pauseCharB,
	output logic [7:0] pauseRepeatCount,
	output logic mode256,
	output logic [7:0] flowUpper,
	output logic [7:0] flowLower,
	output logic [7:0] txTrigger,
	output logic [7:0] rxTrigger
);

	if (ADDR_W <= `REG_SPAN_MSB) begin : g_addr_check
		$error("ADDR_W too small for the register span");
	end

	// ============================================================
	// state
	logic [7:0] intEn_r, intEn_nxt, fifoCtrl_r, fifoCtrl_nxt;
	logic [7:0] lineCtrl_r, lineCtrl_nxt, modemCtrl_r, modemCtrl_nxt;
	logic [7:0] scratch_r, scratch_nxt, divLow_r, divLow_nxt;
	logic [7:0] divHigh_r, divHigh_nxt, key_r, key_nxt;
	logic [7:0] autoTog_r, autoTog_nxt, enhFeat_r, enhFeat_nxt;
	logic [7:0] resA_r, resA_nxt, resB_r, resB_nxt;
	logic [7:0] pauA_r, pauA_nxt, pauB_r, pauB_nxt;
	logic [7:0] extra_r, extra_nxt, repeat_r, repeat_nxt;
	logic [7:0] txTrig_r, txTrig_nxt, rxTrig_r, rxTrig_nxt;
	logic [7:0] flowUp_r, flowUp_nxt, flowLo_r, flowLo_nxt;
	logic [7:0] txEff_r, txEff_nxt, rxEff_r, rxEff_nxt;
	logic [7:0] intSrc_r, intSrc_nxt, lineStat_r, lineStat_nxt;
	logic [3:0] modemHigh_r, modemHigh_nxt;
	logic pageOpen_r, pageOpen_nxt;
	logic txDrv_r, txDrv_nxt, irqLvl_r, irqLvl_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [3:0] modemMeta_r, modemSync_r;
	logic [7:0] lkUp, lkLo, lkRx, lkTx, rdMux, intView, wd;
	logic [2:0] idx;
	logic wrEn, rdSetup, badAddr, wrBase;
	uart_page_pkg::page_t pageNow;

	// ============================================================
	// page decode
	function automatic uart_page_pkg::page_t pageOf(input logic [7:0] lc,
			input logic [7:0] mc, input logic open, input logic fen);
		if (lc == `LINE_FEAT_CODE && open && fen)
			return uart_page_pkg::PAGE_EXT;
		else if (lc == `LINE_FEAT_CODE)
			return uart_page_pkg::PAGE_FEAT;
		else if (lc[`LINE_DIV_BIT])
			return uart_page_pkg::PAGE_DIV;
		else if (mc[`MODEM_PAGE_BIT])
			return uart_page_pkg::PAGE_CNT;
		return uart_page_pkg::PAGE_BASE;
	endfunction : pageOf

	// extended registers and the base ones they overlay both need the page state plus the index
	assign pageNow = pageOf(lineCtrl_r, modemCtrl_r, pageOpen_r,
		fifoCtrl_r[`FIFO_EN_BIT]); // see RQ1 see RQ6
	assign idx = paddr[`REG_IDX_MSB:`REG_IDX_LSB];
	assign wd = pwdata[7:0];
	assign badAddr = (paddr[ADDR_W-1:`REG_SPAN_MSB] != '0)
		|| (paddr[`REG_IDX_LSB-1:0] != '0);
	assign wrEn = ce && psel && penable && pwrite && !badAddr;
	assign rdSetup = ce && psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && badAddr;
	assign prdata = rdata_r;

	fifo_level_lookup u_lookup (
		.ctrlHigh(fifoCtrl_r[7:4]),
		.flowUpper(lkUp),
		.flowLower(lkLo),
		.rxTrig(lkRx),
		.txTrig(lkTx)
	);

	// 256 mode turns the top two source bits into fifo status
	assign intView = extra_r[`MODE256_BIT]
		? {txEmpty256, rxFull256, intSrc_r[5:0]} : intSrc_r; // see RQ19

	// ============================================================
	// read multiplexer
	always_comb begin
		rdMux = `RST_ZERO;
		unique case (idx)
			`IDX_DATA: rdMux = rxData;
			`IDX_INT_EN: rdMux = intEn_r;
			`IDX_INT_SRC: rdMux = intView;
			`IDX_LINE_CTRL: rdMux = lineCtrl_r;
			`IDX_MODEM_CTRL: rdMux = modemCtrl_r;
			`IDX_LINE_STAT: rdMux = lineStat_r;
			`IDX_MODEM_STAT: rdMux = {modemHigh_r, ~modemSync_r}; // see RQ15
			`IDX_SCRATCH: rdMux = scratch_r;
		endcase
		unique case (pageNow)
			uart_page_pkg::PAGE_DIV: begin
				if (idx == `IDX_DIV_LOW) rdMux = divLow_r;
				if (idx == `IDX_DIV_HIGH) rdMux = divHigh_r;
			end
			uart_page_pkg::PAGE_CNT: begin
				if (idx == `IDX_TX_COUNT) rdMux = txCountIn; // see RQ12
				if (idx == `IDX_RX_COUNT) rdMux = rxCountIn; // see RQ12
				if (idx == `IDX_FLOW_STAT) rdMux = flowStatusIn; // see RQ11
			end
			uart_page_pkg::PAGE_FEAT: begin
				if (idx == `IDX_PAGE_KEY) rdMux = key_r;
				if (idx == `IDX_AUTO_TOG) rdMux = autoTog_r;
				if (idx == `IDX_ENH_FEAT) rdMux = enhFeat_r; // see RQ4
				if (idx == `IDX_RESUME_A) rdMux = resA_r; // see RQ3
				if (idx == `IDX_RESUME_B) rdMux = resB_r;
				if (idx == `IDX_PAUSE_A) rdMux = pauA_r;
				if (idx == `IDX_PAUSE_B) rdMux = pauB_r;
			end
			uart_page_pkg::PAGE_EXT: begin
				if (idx == `IDX_PAGE_KEY) rdMux = key_r;
				if (idx == `IDX_REPEAT) rdMux = repeat_r;
				if (idx == `IDX_EXTRA_FEAT) rdMux = extra_r;
				if (idx == `IDX_TX_TRIG) rdMux = txTrig_r;
				if (idx == `IDX_RX_TRIG) rdMux = rxTrig_r;
				if (idx == `IDX_FLOW_UP) rdMux = flowUp_r;
				if (idx == `IDX_FLOW_LO) rdMux = flowLo_r;
			end
			default: ;
		endcase
	end

	// ============================================================
	// next-state of the register file
	always_comb begin
		intEn_nxt = intEn_r;
		fifoCtrl_nxt = fifoCtrl_r;
		lineCtrl_nxt = lineCtrl_r;
		modemCtrl_nxt = modemCtrl_r;
		scratch_nxt = scratch_r;
		divLow_nxt = divLow_r;
		divHigh_nxt = divHigh_r;
		key_nxt = key_r;
		pageOpen_nxt = pageOpen_r;
		autoTog_nxt = autoTog_r;
		enhFeat_nxt = enhFeat_r;
		resA_nxt = resA_r;
		resB_nxt = resB_r;
		pauA_nxt = pauA_r;
		pauB_nxt = pauB_r;
		extra_nxt = extra_r;
		repeat_nxt = repeat_r;
		txTrig_nxt = txTrig_r;
		rxTrig_nxt = rxTrig_r;
		flowUp_nxt = flowUp_r;
		flowLo_nxt = flowLo_r;
		wrBase = wrEn;
		if (wrEn) begin
			unique case (pageNow)
				uart_page_pkg::PAGE_DIV: begin
					if (idx == `IDX_DIV_LOW) begin
						divLow_nxt = wd; // see RQ2
						wrBase = 1'b0;
					end
					if (idx == `IDX_DIV_HIGH) begin
						divHigh_nxt = wd; // see RQ2
						wrBase = 1'b0;
					end
				end
				uart_page_pkg::PAGE_CNT: begin
					// counts and flow status ignore writes
					if (idx <= `IDX_FLOW_STAT) wrBase = 1'b0;
				end
				uart_page_pkg::PAGE_FEAT, uart_page_pkg::PAGE_EXT: begin
					if (idx != `IDX_LINE_CTRL) wrBase = 1'b0;
					if (idx == `IDX_PAGE_KEY) begin
						key_nxt = wd;
						if (wd == `KEY_OPEN) pageOpen_nxt = 1'b1; // see RQ5
						if (wd == `KEY_CLOSE) pageOpen_nxt = 1'b0; // see RQ5
					end
				end
				default: ;
			endcase
			if (pageNow == uart_page_pkg::PAGE_FEAT) begin
				if (idx == `IDX_AUTO_TOG) autoTog_nxt = wd;
				if (idx == `IDX_ENH_FEAT) enhFeat_nxt = wd; // see RQ4
				if (idx == `IDX_RESUME_A) resA_nxt = wd; // see RQ3
				if (idx == `IDX_RESUME_B) resB_nxt = wd; // see RQ3
				if (idx == `IDX_PAUSE_A) pauA_nxt = wd; // see RQ3
				if (idx == `IDX_PAUSE_B) pauB_nxt = wd; // see RQ3
			end
			if (pageNow == uart_page_pkg::PAGE_EXT) begin
				if (idx == `IDX_REPEAT) repeat_nxt = wd;
				if (idx == `IDX_EXTRA_FEAT) extra_nxt = wd; // see RQ19
				if (idx == `IDX_TX_TRIG) txTrig_nxt = wd; // see RQ10
				if (idx == `IDX_RX_TRIG) rxTrig_nxt = wd; // see RQ10
				if (idx == `IDX_FLOW_UP && extra_r[`MODE256_BIT])
					flowUp_nxt = wd; // see RQ7
				if (idx == `IDX_FLOW_LO && extra_r[`MODE256_BIT])
					flowLo_nxt = wd; // see RQ7
			end
		end
		if (wrBase) begin
			unique case (idx)
				`IDX_INT_EN: intEn_nxt = enhFeat_r[`ENH_WE_BIT]
					? wd : {intEn_r[7:4], wd[3:0]};
				`IDX_INT_SRC: fifoCtrl_nxt = enhFeat_r[`ENH_WE_BIT]
					? wd : {wd[7:6], fifoCtrl_r[5:4], wd[3:0]};
				`IDX_LINE_CTRL: lineCtrl_nxt = wd; // see RQ1
				`IDX_MODEM_CTRL: modemCtrl_nxt = enhFeat_r[`ENH_WE_BIT]
					? wd : {modemCtrl_r[7:5], wd[4:0]};
				`IDX_SCRATCH: scratch_nxt = wd;
				default: ;
			endcase
		end
		// 64-byte mode: thresholds are read-only copies of the lookup
		if (!extra_r[`MODE256_BIT]) begin
			flowUp_nxt = lkUp; // see RQ8 see RQ20
			flowLo_nxt = lkLo; // see RQ8 see RQ20
		end
	end

	// ============================================================
	// status capture, pins and read data
	always_comb begin
		intSrc_nxt = intSourceIn;
		lineStat_nxt = lineStatusIn;
		modemHigh_nxt = modemDeltaIn;
		txEff_nxt = extra_r[`MODE256_BIT] ? txTrig_r : lkTx; // see RQ9
		rxEff_nxt = extra_r[`MODE256_BIT] ? rxTrig_r : lkRx; // see RQ9
		txDrv_nxt = (autoTog_r[1:0] == `AUTO_TOG_ON) && txBusy;
		irqLvl_nxt = !intSrc_r[0];
		rdata_nxt = rdSetup ? {24'h000000, rdMux} : rdata_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			intEn_r <= `RST_ZERO; // see RQ14
			fifoCtrl_r <= `RST_ZERO;
			lineCtrl_r <= `RST_ZERO;
			modemCtrl_r <= `RST_ZERO;
			scratch_r <= `RST_ZERO;
			divLow_r <= `RST_DIV; // see RQ13
			divHigh_r <= `RST_DIV;
			key_r <= `RST_ZERO;
			pageOpen_r <= 1'b0;
			autoTog_r <= `RST_AUTO_TOG; // see RQ13
			enhFeat_r <= `RST_ZERO;
			resA_r <= `RST_ZERO;
			resB_r <= `RST_ZERO;
			pauA_r <= `RST_ZERO;
			pauB_r <= `RST_ZERO;
			extra_r <= `RST_ZERO;
			repeat_r <= `RST_ZERO;
			txTrig_r <= `RST_TRIG; // see RQ13
			rxTrig_r <= `RST_TRIG;
			flowUp_r <= `RST_ZERO; // see RQ14
			flowLo_r <= `RST_ZERO;
			txEff_r <= `RST_TRIG;
			rxEff_r <= `RST_TRIG;
			intSrc_r <= `RST_INT_SRC; // see RQ13
			lineStat_r <= `RST_LINE_STAT;
			modemHigh_r <= 4'h0; // see RQ15
			txDrv_r <= 1'b0; // see RQ18
			irqLvl_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end else if (ce) begin
			intEn_r <= intEn_nxt;
			fifoCtrl_r <= fifoCtrl_nxt;
			lineCtrl_r <= lineCtrl_nxt;
			modemCtrl_r <= modemCtrl_nxt;
			scratch_r <= scratch_nxt;
			divLow_r <= divLow_nxt;
			divHigh_r <= divHigh_nxt;
			key_r <= key_nxt;
			pageOpen_r <= pageOpen_nxt;
			autoTog_r <= autoTog_nxt;
			enhFeat_r <= enhFeat_nxt;
			resA_r <= resA_nxt;
			resB_r <= resB_nxt;
			pauA_r <= pauA_nxt;
			pauB_r <= pauB_nxt;
			extra_r <= extra_nxt;
			repeat_r <= repeat_nxt;
			txTrig_r <= txTrig_nxt;
			rxTrig_r <= rxTrig_nxt;
			flowUp_r <= flowUp_nxt;
			flowLo_r <= flowLo_nxt;
			txEff_r <= txEff_nxt;
			rxEff_r <= rxEff_nxt;
			intSrc_r <= intSrc_nxt;
			lineStat_r <= lineStat_nxt;
			modemHigh_r <= modemHigh_nxt;
			txDrv_r <= txDrv_nxt;
			irqLvl_r <= irqLvl_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// modem pins come from outside: two flip-flops before use
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			modemMeta_r <= 4'h0;
			modemSync_r <= 4'h0;
		end else if (ce) begin
			modemMeta_r <= modemPins;
			modemSync_r <= modemMeta_r;
		end
	end

	// in reset the irq pin floats or sinks as the select pin asks
	assign irqOe = rst ? irqDriveSelect : 1'b1; // see RQ16 see RQ17
	assign irqOut = rst ? 1'b0 : irqLvl_r; // see RQ17
	assign txDriverEnable = txDrv_r; // see RQ18
	assign rxReceiverEnableN = txDrv_r;
	assign divisor = {divHigh_r, divLow_r};
	assign lineControl = lineCtrl_r;
	assign modemControl = modemCtrl_r;
	assign fifoControl = fifoCtrl_r;
	assign interruptEnable = intEn_r;
	assign enhancedFeature = enhFeat_r;
	assign resumeCharA = resA_r;
	assign resumeCharB = resB_r;
	assign pauseCharA = pauA_r;
	assign pauseCharB = pauB_r;
	assign pauseRepeatCount = repeat_r;
	assign mode256 = extra_r[`MODE256_BIT];
	assign flowUpper = flowUp_r;
	assign flowLower = flowLo_r;
	assign txTrigger = txEff_r;
	assign rxTrigger = rxEff_r;

	// ============================================================
	// assertions
	div_write_a: assert property (@(posedge clk) disable iff (rst)
		wrEn && pageNow == uart_page_pkg::PAGE_DIV && idx == `IDX_DIV_HIGH
		|=> divisor[15:8] == $past(pwdata[7:0])) // see RQ2
		else $error("divisor high latch not written");
	char_write_a: assert property (@(posedge clk) disable iff (rst)
		wrEn && pageNow == uart_page_pkg::PAGE_FEAT && idx == `IDX_PAUSE_B
		|=> pauseCharB == $past(pwdata[7:0])) // see RQ3
		else $error("pause character not written");
	feat_write_a: assert property (@(posedge clk) disable iff (rst)
		wrEn && pageNow == uart_page_pkg::PAGE_FEAT && idx == `IDX_ENH_FEAT
		|=> enhancedFeature == $past(pwdata[7:0])) // see RQ4
		else $error("enhanced feature not written");
	key_open_a: assert property (@(posedge clk) disable iff (rst)
		wrEn && lineCtrl_r == `LINE_FEAT_CODE && idx == `IDX_PAGE_KEY
		&& pwdata[7:0] == `KEY_OPEN ##1 fifoControl[`FIFO_EN_BIT]
		|-> pageNow == uart_page_pkg::PAGE_EXT) // see RQ5
		else $error("extended page not opened");
	flow_follow_a: assert property (@(posedge clk) disable iff (rst)
		!rst && ce && !mode256 ##1 ce |-> flowUpper == $past(lkUp)
		&& flowLower == $past(lkLo)) // see RQ8
		else $error("64-byte thresholds do not follow control");
	trig_follow_a: assert property (@(posedge clk) disable iff (rst)
		ce && !mode256 && fifoControl[7:4] == 4'hA
		|=> txTrigger == `LVL_32 && rxTrigger == `LVL_56) // see RQ9
		else $error("64-byte trigger levels wrong");
	count_read_a: assert property (@(posedge clk) disable iff (rst)
		rdSetup && pageNow == uart_page_pkg::PAGE_CNT
		&& idx == `IDX_RX_COUNT |=> prdata[7:0] == $past(rxCountIn)) // see RQ12
		else $error("rx count not returned");
	isr_view_a: assert property (@(posedge clk) disable iff (rst)
		rdSetup && mode256 && pageNow == uart_page_pkg::PAGE_BASE
		&& idx == `IDX_INT_SRC
		|=> prdata[7:6] == {$past(txEmpty256), $past(rxFull256)}) // see RQ19
		else $error("256-byte source bits wrong");
	irq_reset_a: assert property (@(posedge clk)
		rst |-> irqOe == irqDriveSelect && !irqOut) // see RQ16
		else $error("irq pin wrong during reset");
	pins_reset_a: assert property (@(posedge clk)
		$fell(rst) |-> !txDriverEnable && !rxReceiverEnableN
		&& divisor == 16'hFFFF) // see RQ18
		else $error("pins or divisor wrong after reset");

endmodule : uart_page_regfile

// *** dv/test_uart_page_regfile.sv ***
// self-checking bench for the paged uart register file
module test_uart_page_regfile;
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// stimulus and observed signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, irqOut, irqOe, txDriverEnable, rxReceiverEnableN;
	logic [7:0] rxData = 8'h5A, intSourceIn = 8'h04, lineStatusIn = 8'h61;
	logic [7:0] txCountIn = 8'h00, rxCountIn = 8'h00, flowStatusIn = 8'h00;
	logic [3:0] modemDeltaIn = 4'h0, modemPins = 4'hA;
	logic txEmpty256 = 1'b1, rxFull256 = 1'b0, txBusy = 1'b0;
	logic irqDriveSelect = 1'b0;
	logic [15:0] divisor;
	logic [7:0] lineControl, modemControl, fifoControl, interruptEnable;
	logic [7:0] enhancedFeature, resumeCharA, resumeCharB, pauseCharA;
	logic [7:0] pauseCharB, pauseRepeatCount, flowUpper, flowLower;
	logic [7:0] txTrigger, rxTrigger;
	logic mode256;
	int n_fail = 0;
	int n_compared = 0;

	uart_page_regfile i_dut (
		.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxData(rxData),
		.intSourceIn(intSourceIn), .lineStatusIn(lineStatusIn),
		.modemDeltaIn(modemDeltaIn), .txCountIn(txCountIn),
		.rxCountIn(rxCountIn), .flowStatusIn(flowStatusIn),
		.txEmpty256(txEmpty256), .rxFull256(rxFull256), .txBusy(txBusy),
		.modemPins(modemPins), .irqDriveSelect(irqDriveSelect),
		.irqOut(irqOut), .irqOe(irqOe), .txDriverEnable(txDriverEnable),
		.rxReceiverEnableN(rxReceiverEnableN), .divisor(divisor),
		.lineControl(lineControl), .modemControl(modemControl),
		.fifoControl(fifoControl), .interruptEnable(interruptEnable),
		.enhancedFeature(enhancedFeature), .resumeCharA(resumeCharA),
		.resumeCharB(resumeCharB), .pauseCharA(pauseCharA),
		.pauseCharB(pauseCharB), .pauseRepeatCount(pauseRepeatCount),
		.mode256(mode256), .flowUpper(flowUpper), .flowLower(flowLower),
		.txTrigger(txTrigger), .rxTrigger(rxTrigger)
	);

	always #5 clk = ~clk;

	// ============================================================
	// shared tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task report_and_stop;
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	// one apb transfer; hi sets an address bit outside the register span
	task apb(input logic wr, input logic [2:0] idx, input logic [7:0] d,
		input logic hi, output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {6'h00, hi, idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [2:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, d, 1'b0, r, e);
	endtask : wr

	task rd(input string nm, input logic [2:0] idx, input logic [7:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, idx, 8'h00, 1'b0, r, e);
		chk(nm, r, {24'h000000, x});
	endtask : rd

	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	// ============================================================
	// scenarios
	task t_reset;
		chk("irqOe low sel", irqOe, 1'b0);
		@(posedge clk);
		irqDriveSelect <= 1'b1;
		@(posedge clk);
		#1;
		chk("irqOe high sel", irqOe, 1'b1);
		chk("irqOut", irqOut, 1'b0);
		chk("enables", {txDriverEnable, rxReceiverEnableN}, 2'h0);
		chk("divisor", divisor, 16'hFFFF);
		chk("triggers", {txTrigger, rxTrigger}, 16'h8080);
		chk("ctrl", {lineControl, modemControl, fifoControl}, 24'h0);
		chk("feat", {interruptEnable, enhancedFeature, mode256}, 17'h0);
		chk("chars", {resumeCharA, resumeCharB, pauseCharA, pauseCharB}, 0);
		chk("thr", {pauseRepeatCount, flowUpper, flowLower}, 24'h0);
	endtask : t_reset

	task t_after_reset;
		rd("line ctrl", 3'h3, 8'h00);
		rd("int enable", 3'h1, 8'h00);
		wr(3'h1, 8'hFF);
		rd("int en masked", 3'h1, 8'h0F);
		wr(3'h1, 8'h00);
		rd("scratch", 3'h7, 8'h00);
		rd("rx data", 3'h0, 8'h5A);
		rd("int source 64", 3'h2, 8'h04);
		rd("line status", 3'h5, 8'h61);
		rd("modem status", 3'h6, 8'h05);
		wr(3'h3, 8'hBF);
		rd("auto toggle", 3'h1, 8'hA0);
		rd("key", 3'h0, 8'h00);
		rd("enh feature", 3'h2, 8'h00);
		for (int i = 4; i < 8; i++) begin
			rd("flow char", i[2:0], 8'h00);
		end
		txBusy <= 1'b1;
		settle;
		chk("idle enables", {txDriverEnable, rxReceiverEnableN}, 2'h0);
		wr(3'h1, 8'h03);
		settle;
		chk("toggle enables", {txDriverEnable, rxReceiverEnableN}, 2'h3);
		wr(3'h1, 8'hA0);
		txBusy <= 1'b0;
	endtask : t_after_reset

	task t_divisor;
		wr(3'h3, 8'h80);
		rd("div low rst", 3'h0, 8'hFF);
		rd("div high rst", 3'h1, 8'hFF);
		wr(3'h0, 8'h34);
		wr(3'h1, 8'h12);
		settle;
		chk("divisor", divisor, 16'h1234);
		rd("div low", 3'h0, 8'h34);
		rd("div high", 3'h1, 8'h12);
		wr(3'h3, 8'h03);
		rd("base idx0", 3'h0, 8'h5A);
		rd("base idx1", 3'h1, 8'h00);
	endtask : t_divisor

	task t_feature;
		wr(3'h3, 8'hBF);
		for (int i = 4; i < 8; i++) begin
			wr(i[2:0], 8'hC0 + 8'(i));
		end
		wr(3'h2, 8'h1F);
		settle;
		chk("chars", {resumeCharA, resumeCharB, pauseCharA, pauseCharB}, 32'hC4C5C6C7);
		chk("enh feature", enhancedFeature, 8'h1F);
		for (int i = 4; i < 8; i++) begin
			rd("flow char", i[2:0], 8'hC0 + 8'(i));
		end
		rd("enh feature", 3'h2, 8'h1F);
	endtask : t_feature

	task t_levels;
		logic [3:0] code[4];
		logic [31:0] lvl[4];
		code = '{4'h0, 4'h5, 4'hA, 4'hF};
		lvl = '{32'h08000808, 32'h10081010, 32'h38103820, 32'h3C383C38};
		wr(3'h3, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(3'h2, {code[i], 4'h1});
			settle;
			chk("thresholds", {flowUpper, flowLower}, lvl[i][31:16]);
			chk("triggers", {rxTrigger, txTrigger}, lvl[i][15:0]);
		end
	endtask : t_levels

	task t_ext;
		wr(3'h2, 8'hF0);
		wr(3'h3, 8'hBF);
		wr(3'h0, 8'hA5);
		rd("no fifo enable", 3'h2, 8'h1F);
		wr(3'h3, 8'h00);
		wr(3'h2, 8'hF1);
		wr(3'h3, 8'hBF);
		rd("extra feature", 3'h2, 8'h00);
		rd("flow up 64", 3'h6, 8'h3C);
		wr(3'h6, 8'h99);
		rd("flow up lost", 3'h6, 8'h3C);
		wr(3'h2, 8'h01);
		settle;
		chk("mode256", mode256, 1'b1);
		wr(3'h6, 8'h40);
		wr(3'h7, 8'h10);
		wr(3'h4, 8'h24);
		wr(3'h5, 8'h44);
		wr(3'h1, 8'h03);
		settle;
		chk("thresholds", {flowUpper, flowLower}, 16'h4010);
		chk("triggers", {txTrigger, rxTrigger}, 16'h2444);
		chk("repeat", pauseRepeatCount, 8'h03);
		rd("flow lo", 3'h7, 8'h10);
		rd("rx trig", 3'h5, 8'h44);
		wr(3'h0, 8'hA4);
		rd("page closed", 3'h2, 8'h1F);
		wr(3'h3, 8'h03);
		rd("int source 256", 3'h2, 8'h84);
	endtask : t_ext

	task t_count;
		txCountIn <= 8'h11;
		rxCountIn <= 8'h22;
		flowStatusIn <= 8'h33;
		wr(3'h4, 8'h40);
		rd("tx count", 3'h0, 8'h11);
		rd("rx count", 3'h1, 8'h22);
		rd("flow status", 3'h2, 8'h33);
		wr(3'h4, 8'h00);
		rd("restored", 3'h0, 8'h5A);
	endtask : t_count

	task t_bad;
		logic [31:0] r;
		logic e;
		apb(1'b1, 3'h7, 8'hEE, 1'b1, r, e);
		chk("slave error", e, 1'b1);
		chk("ready", pready, 1'b1);
		rd("scratch kept", 3'h7, 8'h00);
		ce <= 1'b0;
		wr(3'h7, 8'h77);
		ce <= 1'b1;
		rd("scratch frozen", 3'h7, 8'h00);
		wr(3'h7, 8'h55);
		rd("scratch", 3'h7, 8'h55);
	endtask : t_bad

	// ============================================================
	// main sequence and watchdog
	initial begin
		repeat (2) @(posedge clk);
		#1;
		t_reset;
		@(posedge clk);
		rst <= 1'b0;
		t_after_reset;
		t_divisor;
		t_feature;
		t_levels;
		t_ext;
		t_count;
		t_bad;
		report_and_stop;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop;
	end

endmodule : test_uart_page_regfile
